// [common/iap_pkg.sv]
// Constants, register map and carrier types of the flash programming controller
package iap_pkg;
  localparam int ADDR_W = 15;
  localparam int WORD_W = 16;
  localparam int PAGE_WORDS = 64;
  localparam int IDX_W = 6;
  localparam logic [IDX_W-1:0] LAST_WORD = 6'h3F;

  // Register offsets inside the flash access window
  localparam logic [7:0] OFF_CTRL = 8'h43;
  localparam logic [7:0] OFF_RESET_KEY = 8'h44;
  localparam logic [7:0] OFF_BUF_CLEAR = 8'h45;
  localparam logic [7:0] OFF_ADDR_LOW = 8'h46;
  localparam logic [7:0] OFF_ADDR_HIGH = 8'h47;
  localparam logic [7:0] OFF_DW0_LOW = 8'h48;
  localparam logic [7:0] OFF_DW0_HIGH = 8'h49;
  localparam logic [7:0] OFF_DW1_LOW = 8'h4A;
  localparam logic [7:0] OFF_DW3_HIGH = 8'h4F;

  // Field positions
  localparam int BIT_WRITE_ENABLED = 7;
  localparam int BIT_UNLOCK_EN = 3;
  localparam int BIT_WRITE_START = 2;
  localparam int BIT_READ_EN = 1;
  localparam int BIT_READ_START = 0;
  localparam int BIT_BUF_CLEAR = 0;
  localparam int MODE_LSB = 4;
  localparam int ADDR_HIGH_W = 7;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [WORD_W-1:0] BUF_CLEAR_VALUE = 16'hFFFF;

  // Operation mode codes
  localparam logic [2:0] MODE_WRITE = 3'h0;
  localparam logic [2:0] MODE_ERASE = 3'h1;
  localparam logic [2:0] MODE_READ = 3'h3;
  localparam logic [2:0] MODE_UNLOCK = 3'h6;

  localparam logic [7:0] CHIP_RESET_VALUE = 8'h55;
  localparam int KEY_LEN = 6;
  localparam logic [2:0] KEY_LAST = 3'h5;
  localparam logic [KEY_LEN-1:0][7:0] UNLOCK_KEY = {8'h40, 8'hC3, 8'h09, 8'h0D, 8'h04, 8'h00};

  // Unlock window measured in sub clock periods, rounded down
  localparam int UNLOCK_TIMEOUT_US = 300;
  localparam int SUB_CLOCK_HZ = 32768;
  localparam int TIMEOUT_TICKS = (UNLOCK_TIMEOUT_US * SUB_CLOCK_HZ) / 1000000;
  localparam int TMO_W = $clog2(TIMEOUT_TICKS + 1);
  localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(TIMEOUT_TICKS - 1);

  typedef enum logic [2:0] {IAP_IDLE, IAP_UNLOCK, IAP_CLEAR, IAP_ERASE, IAP_WR_FETCH, IAP_WR_REQ, IAP_READ} iap_fsm_t;
  typedef enum logic [1:0] {IAP_OP_WRITE, IAP_OP_ERASE, IAP_OP_READ} iap_op_t;

  // Main control register, laid out as read back
  typedef struct packed {
    logic write_enabled;
    logic [2:0] mode;
    logic unlock_en;
    logic write_start;
    logic read_en;
    logic read_start;
  } iap_ctrl_t;

  typedef struct packed {
    logic req;
    iap_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } iap_flash_cmd_t;

  typedef struct packed {
    iap_ctrl_t ctrl;
    logic [7:0] chip_key;
    logic buf_clear;
    logic [ADDR_W-1:0] addr;
    logic [3:0][WORD_W-1:0] data;
    iap_fsm_t fsm;
    logic [2:0] key_idx;
    logic [TMO_W-1:0] tmo;
    logic [2:0] sub_sync;
    logic sub_lvl;
    logic [IDX_W-1:0] idx;
    logic req;
    iap_op_t op;
    logic [ADDR_W-1:0] cmd_addr;
    logic chip_reset;
    logic [7:0] rdata;
  } iap_state_t;
endpackage

// [hw/iap_flash_access_control.sv]
// In-application flash programming controller: registers, unlock, buffer load and flash sequencing
// Function
// - Writing 55H to reset key resets chip
// - Buffer clear bit starts clear, hardware ends it
// - Buffer clear register bits 7..1 read zero
// - Fifteen-bit address, high byte bit 7 zero
// - Data word 0 low write stays local
// - Data word 0 high loads buffer, increments address
// - Data words 1..3 are byte pairs, reset zero
// - Six key bytes written in order, compared
// - Unlock times out after 9 sub clock periods (300us rounded down)
// - Timeout or bad key drops enable bit
// - Good key sets write-enabled, drops enable bit
// - Clearing write-enabled blocks writes and erases
// - Erase page from address bits 14..6 only
// - CPU halted while write or read runs
// - Mode codes write, erase, read, unlock
// - Software cannot set write-enabled bit
// - Write start cleared by hardware when done
// - Read start with read enable in read mode runs read
`timescale 1ns/100ps
module iap_flash_access_control #(
  parameter int BUF_DEPTH = iap_pkg::PAGE_WORDS
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sub_clock,
  input wire logic [7:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  output logic cpu_halt,
  output logic chip_reset,
  output iap_pkg::iap_flash_cmd_t flash_cmd,
  input wire logic flash_done,
  input wire logic [iap_pkg::WORD_W-1:0] flash_rdata
);
  iap_pkg::iap_state_t s;
  iap_pkg::iap_state_t n;
  logic sub_tick;
  logic buf_we;
  logic [iap_pkg::IDX_W-1:0] buf_waddr;
  logic [iap_pkg::WORD_W-1:0] buf_wdata;
  logic [iap_pkg::WORD_W-1:0] buf_rdata;
  logic [7:0] dw_off;
  logic key_write;
  logic [7:0] key_addr;
  if (BUF_DEPTH != iap_pkg::PAGE_WORDS)
  begin : g_check
    $error("Buffer depth must match the erase page size");
  end
  iap_word_buffer #(
    .WIDTH(iap_pkg::WORD_W),
    .DEPTH(BUF_DEPTH),
    .AW(iap_pkg::IDX_W)
  ) u_buffer (
    .clk(clk),
    .nrst(nrst),
    .we(buf_we),
    .waddr(buf_waddr),
    .wdata(buf_wdata),
    .raddr(s.idx),
    .rdata(buf_rdata)
  );
  assign dw_off = cpu_addr - iap_pkg::OFF_DW0_LOW;
  assign key_write = cpu_wr && cpu_addr >= iap_pkg::OFF_DW1_LOW && cpu_addr <= iap_pkg::OFF_DW3_HIGH;
  assign key_addr = iap_pkg::OFF_DW1_LOW + {5'h00, s.key_idx};
  always_comb
  begin
    n = s;
    n.chip_reset = 1'b0;
    buf_we = 1'b0;
    buf_waddr = s.addr[iap_pkg::IDX_W-1:0];
    buf_wdata = {cpu_wdata, s.data[0][7:0]};
    // Sub clock pin: level accepted once the last two stages agree
    n.sub_sync = {s.sub_sync[1:0], sub_clock};
    if (s.sub_sync[1] == s.sub_sync[2])
    begin
      n.sub_lvl = s.sub_sync[2];
    end
    sub_tick = n.sub_lvl & ~s.sub_lvl;
    // Register reads, answered one cycle later
    n.rdata = iap_pkg::REG_RESET;
    if (cpu_rd)
    begin
      case (cpu_addr)
        iap_pkg::OFF_CTRL: n.rdata = s.ctrl;
        iap_pkg::OFF_RESET_KEY: n.rdata = s.chip_key;
        iap_pkg::OFF_BUF_CLEAR: n.rdata = {7'h00, s.buf_clear};
        iap_pkg::OFF_ADDR_LOW: n.rdata = s.addr[7:0];
        iap_pkg::OFF_ADDR_HIGH: n.rdata = {1'b0, s.addr[14:8]};
        default:
        begin
          if (cpu_addr >= iap_pkg::OFF_DW0_LOW && cpu_addr <= iap_pkg::OFF_DW3_HIGH)
          begin
            n.rdata = dw_off[0] ? s.data[dw_off[2:1]][15:8] : s.data[dw_off[2:1]][7:0];
          end
        end
      endcase
    end
    // Register writes
    if (cpu_wr)
    begin
      case (cpu_addr)
        iap_pkg::OFF_CTRL:
        begin
          n.ctrl.mode = cpu_wdata[iap_pkg::MODE_LSB +: 3];
          n.ctrl.unlock_en = cpu_wdata[iap_pkg::BIT_UNLOCK_EN];
          n.ctrl.read_en = cpu_wdata[iap_pkg::BIT_READ_EN];
          if (!cpu_wdata[iap_pkg::BIT_WRITE_ENABLED])
          begin
            n.ctrl.write_enabled = 1'b0;
          end
          if (cpu_wdata[iap_pkg::BIT_WRITE_START])
          begin
            n.ctrl.write_start = 1'b1;
          end
          if (cpu_wdata[iap_pkg::BIT_READ_START])
          begin
            n.ctrl.read_start = 1'b1;
          end
        end
        iap_pkg::OFF_RESET_KEY:
        begin
          n.chip_key = cpu_wdata;
          n.chip_reset = (cpu_wdata == iap_pkg::CHIP_RESET_VALUE);
        end
        iap_pkg::OFF_BUF_CLEAR:
        begin
          if (cpu_wdata[iap_pkg::BIT_BUF_CLEAR])
          begin
            n.buf_clear = 1'b1;
          end
        end
        iap_pkg::OFF_ADDR_LOW: n.addr[7:0] = cpu_wdata;
        iap_pkg::OFF_ADDR_HIGH: n.addr[14:8] = cpu_wdata[iap_pkg::ADDR_HIGH_W-1:0];
        default:
        begin
          if (cpu_addr >= iap_pkg::OFF_DW0_LOW && cpu_addr <= iap_pkg::OFF_DW3_HIGH)
          begin
            if (dw_off[0])
            begin
              n.data[dw_off[2:1]][15:8] = cpu_wdata;
            end
            else
            begin
              n.data[dw_off[2:1]][7:0] = cpu_wdata;
            end
          end
          if (cpu_addr == iap_pkg::OFF_DW0_HIGH)
          begin
            buf_we = 1'b1;
            n.addr = s.addr + 15'h0001;
          end
        end
      endcase
    end
    case (s.fsm)
      iap_pkg::IAP_IDLE:
      begin
        if (s.ctrl.unlock_en && s.ctrl.mode == iap_pkg::MODE_UNLOCK)
        begin
          n.fsm = iap_pkg::IAP_UNLOCK;
          n.key_idx = 3'h0;
          n.tmo = '0;
        end
        else if (s.buf_clear)
        begin
          n.fsm = iap_pkg::IAP_CLEAR;
          n.idx = '0;
        end
        else if (s.ctrl.write_start)
        begin
          // Without a successful unlock the start bit is dropped unserved
          if (s.ctrl.write_enabled && s.ctrl.mode == iap_pkg::MODE_WRITE)
          begin
            n.fsm = iap_pkg::IAP_WR_FETCH;
            n.idx = '0;
          end
          else if (s.ctrl.write_enabled && s.ctrl.mode == iap_pkg::MODE_ERASE)
          begin
            n.fsm = iap_pkg::IAP_ERASE;
            n.req = 1'b1;
            n.op = iap_pkg::IAP_OP_ERASE;
            n.cmd_addr = {s.addr[14:6], 6'h00};
          end
          else
          begin
            n.ctrl.write_start = 1'b0;
          end
        end
        else if (s.ctrl.read_start)
        begin
          if (s.ctrl.read_en && s.ctrl.mode == iap_pkg::MODE_READ)
          begin
            n.fsm = iap_pkg::IAP_READ;
            n.req = 1'b1;
            n.op = iap_pkg::IAP_OP_READ;
            n.cmd_addr = s.addr;
          end
          else
          begin
            n.ctrl.read_start = 1'b0;
          end
        end
      end
      iap_pkg::IAP_UNLOCK:
      begin
        if (!n.ctrl.unlock_en || n.ctrl.mode != iap_pkg::MODE_UNLOCK)
        begin
          n.fsm = iap_pkg::IAP_IDLE;
        end
        else if (key_write)
        begin
          if (cpu_addr == key_addr && cpu_wdata == iap_pkg::UNLOCK_KEY[s.key_idx])
          begin
            if (s.key_idx == iap_pkg::KEY_LAST)
            begin
              n.ctrl.write_enabled = 1'b1;
              n.ctrl.unlock_en = 1'b0;
              n.fsm = iap_pkg::IAP_IDLE;
            end
            else
            begin
              n.key_idx = s.key_idx + 3'h1;
            end
          end
          else
          begin
            n.ctrl.unlock_en = 1'b0;
            n.fsm = iap_pkg::IAP_IDLE;
          end
        end
        else if (sub_tick)
        begin
          if (s.tmo == iap_pkg::TMO_LAST)
          begin
            n.ctrl.unlock_en = 1'b0;
            n.fsm = iap_pkg::IAP_IDLE;
          end
          else
          begin
            n.tmo = s.tmo + 1'b1;
          end
        end
      end
      iap_pkg::IAP_CLEAR:
      begin
        // Clearing owns the buffer port over a concurrent word load
        buf_we = 1'b1;
        buf_waddr = s.idx;
        buf_wdata = iap_pkg::BUF_CLEAR_VALUE;
        if (s.idx == iap_pkg::LAST_WORD)
        begin
          n.buf_clear = cpu_wr && cpu_addr == iap_pkg::OFF_BUF_CLEAR && cpu_wdata[iap_pkg::BIT_BUF_CLEAR];
          n.fsm = iap_pkg::IAP_IDLE;
        end
        else
        begin
          n.idx = s.idx + 1'b1;
        end
      end
      iap_pkg::IAP_ERASE:
      begin
        if (flash_done)
        begin
          n.req = 1'b0;
          n.ctrl.write_start = 1'b0;
          n.fsm = iap_pkg::IAP_IDLE;
        end
      end
      iap_pkg::IAP_WR_FETCH:
      begin
        n.req = 1'b1;
        n.op = iap_pkg::IAP_OP_WRITE;
        n.cmd_addr = {s.addr[14:6], s.idx};
        n.fsm = iap_pkg::IAP_WR_REQ;
      end
      iap_pkg::IAP_WR_REQ:
      begin
        if (flash_done)
        begin
          n.req = 1'b0;
          if (s.idx == iap_pkg::LAST_WORD)
          begin
            n.ctrl.write_start = 1'b0;
            n.fsm = iap_pkg::IAP_IDLE;
          end
          else
          begin
            n.idx = s.idx + 1'b1;
            n.fsm = iap_pkg::IAP_WR_FETCH;
          end
        end
      end
      iap_pkg::IAP_READ:
      begin
        if (flash_done)
        begin
          n.req = 1'b0;
          n.data[0] = flash_rdata;
          n.ctrl.read_start = 1'b0;
          n.fsm = iap_pkg::IAP_IDLE;
        end
      end
      default:
      begin
        n.fsm = iap_pkg::IAP_IDLE;
        n.req = 1'b0;
      end
    endcase
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s <= '0;
    end
    else
    begin
      s <= n;
    end
  end
  assign cpu_rdata = s.rdata;
  assign cpu_halt = s.ctrl.write_start | s.ctrl.read_start;
  assign chip_reset = s.chip_reset;
  assign flash_cmd = '{req: s.req, op: s.op, addr: s.cmd_addr, wdata: buf_rdata};
  chip_reset_a: assert property (@(posedge clk) disable iff (!nrst)
    cpu_wr && cpu_addr == iap_pkg::OFF_RESET_KEY && cpu_wdata == 8'h55 |=> chip_reset ##1 !chip_reset)
    else $error("Reset key did not give a one-cycle chip reset");
  clear_readback_a: assert property (@(posedge clk) disable iff (!nrst)
    cpu_rd && cpu_addr == iap_pkg::OFF_BUF_CLEAR |=> cpu_rdata[7:1] == 7'h00)
    else $error("Buffer clear register upper bits not zero");
  addr_high_rb_a: assert property (@(posedge clk) disable iff (!nrst)
    cpu_rd && cpu_addr == iap_pkg::OFF_ADDR_HIGH |=> cpu_rdata == {1'b0, $past(s.addr[14:8])})
    else $error("Address high readback wrong");
  low_no_load_a: assert property (@(posedge clk) disable iff (!nrst)
    cpu_wr && cpu_addr == iap_pkg::OFF_DW0_LOW && s.fsm != iap_pkg::IAP_CLEAR |-> !buf_we)
    else $error("Low data byte write touched the buffer");
  high_load_a: assert property (@(posedge clk) disable iff (!nrst)
    cpu_wr && cpu_addr == iap_pkg::OFF_DW0_HIGH && s.fsm != iap_pkg::IAP_CLEAR
    |-> buf_we && buf_wdata == {cpu_wdata, s.data[0][7:0]} ##1 s.addr == $past(s.addr) + 15'h0001)
    else $error("High data byte write did not load and advance");
  unlock_tmo_a: assert property (@(posedge clk) disable iff (!nrst)
    s.fsm == iap_pkg::IAP_UNLOCK && sub_tick && s.tmo == iap_pkg::TMO_LAST && !cpu_wr
    |=> !s.ctrl.unlock_en && s.fsm == iap_pkg::IAP_IDLE && s.ctrl.write_enabled == $past(s.ctrl.write_enabled))
    else $error("Unlock timeout not handled");
  unlock_ok_a: assert property (@(posedge clk) disable iff (!nrst)
    s.fsm == iap_pkg::IAP_UNLOCK && s.ctrl.unlock_en && s.ctrl.mode == 3'h6 && s.key_idx == 3'h5
    && cpu_wr && cpu_addr == 8'h4F && cpu_wdata == 8'h40 |=> s.ctrl.write_enabled && !s.ctrl.unlock_en)
    else $error("Correct key did not enable writing");
  no_sw_enable_a: assert property (@(posedge clk) disable iff (!nrst)
    !s.ctrl.write_enabled && s.fsm != iap_pkg::IAP_UNLOCK |=> !s.ctrl.write_enabled)
    else $error("Write-enabled set outside a successful unlock");
  erase_page_a: assert property (@(posedge clk) disable iff (!nrst)
    flash_cmd.req && flash_cmd.op != iap_pkg::IAP_OP_READ
    |-> s.ctrl.write_enabled && (flash_cmd.op != iap_pkg::IAP_OP_ERASE || flash_cmd.addr[5:0] == 6'h00))
    else $error("Flash write or erase issued wrongly");
  halt_start_a: assert property (@(posedge clk) disable iff (!nrst)
    cpu_wr && cpu_addr == iap_pkg::OFF_CTRL && cpu_wdata[2] |=> cpu_halt)
    else $error("CPU not halted after write start");
  read_done_a: assert property (@(posedge clk) disable iff (!nrst)
    s.fsm == iap_pkg::IAP_READ && flash_done |=> !cpu_halt && s.data[0] == $past(flash_rdata))
    else $error("Read completion not handled");
endmodule

// [hw/iap_word_buffer.sv]
// Flash write buffer: one write port, registered read port
`timescale 1ns/100ps
module iap_word_buffer #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] rdata;
  } iap_buf_state_t;

  iap_buf_state_t buf_reg;
  iap_buf_state_t buf_next;

  if (DEPTH != (1 << AW) || WIDTH < 1)
  begin : g_check
    $error("Buffer depth must equal two to the address width");
  end

  always_comb
  begin
    buf_next = buf_reg;
    buf_next.rdata = buf_reg.mem[raddr];
    if (we)
    begin
      buf_next.mem[waddr] = wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      buf_reg <= '0;
    end
    else
    begin
      buf_reg <= buf_next;
    end
  end

  assign rdata = buf_reg.rdata;
endmodule

// [verif/iap_flash_access_control_tb_top.sv]
// Testbench: register access, unlock, erase, page write and read
`timescale 1ns/100ps
module iap_flash_access_control_tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic sub_clock = 1'b0;
  logic [7:0] cpu_addr = 8'h00;
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  logic [7:0] cpu_wdata = 8'h00;
  logic [7:0] cpu_rdata;
  logic cpu_halt;
  logic chip_reset;
  iap_pkg::iap_flash_cmd_t flash_cmd;
  logic flash_done;
  logic [15:0] flash_rdata;
  int n_req;
  int n_mismatch = 0;
  int n_tests = 0;
  int seed = 32'h3d55c1eb;
  int n0;
  logic [7:0] exp_q [$];
  logic rd_seen = 1'b0;
  logic [7:0] key [6] = '{8'h00, 8'h04, 8'h0D, 8'h09, 8'hC3, 8'h40};
  logic [15:0] page_buf [64];
  logic [14:0] base;
  logic [14:0] nxt;
  logic [5:0] idx;

  always #2 clk = ~clk;

  iap_flash_access_control dut (
    .clk(clk),
    .nrst(nrst),
    .sub_clock(sub_clock),
    .cpu_addr(cpu_addr),
    .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd),
    .cpu_wdata(cpu_wdata),
    .cpu_rdata(cpu_rdata),
    .cpu_halt(cpu_halt),
    .chip_reset(chip_reset),
    .flash_cmd(flash_cmd),
    .flash_done(flash_done),
    .flash_rdata(flash_rdata)
  );

  iap_flash_model flash (
    .clk(clk),
    .nrst(nrst),
    .flash_cmd(flash_cmd),
    .flash_done(flash_done),
    .flash_rdata(flash_rdata),
    .n_req(n_req)
  );

  task automatic check_rd(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (n_mismatch == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(negedge clk);
    cpu_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    cpu_addr = a;
    cpu_rd = 1'b1;
    exp_q.push_back(e);
    @(negedge clk);
    cpu_rd = 1'b0;
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    while (cpu_halt !== 1'b0 && k < 2000)
    begin
      @(negedge clk);
      k++;
    end
    check_flag(cpu_halt, 1'b0);
  endtask

  task automatic unlock(input logic [7:0] bad);
    wr(8'h43, 8'h68);
    for (int i = 0; i < 6; i++)
      wr(8'h4A + 8'(i), key[i] ^ ((i == 5) ? bad : 8'h00));
  endtask

  task automatic fetch(input logic [14:0] a, input logic [15:0] e);
    wr(8'h46, a[7:0]);
    wr(8'h47, {1'b0, a[14:8]});
    wr(8'h43, 8'hB3);
    wait_idle;
    rd(8'h48, e[7:0]);
    rd(8'h49, e[15:8]);
    rd(8'h43, 8'hB2);
    rd(8'h46, a[7:0]);
  endtask

  // Read data lands the cycle after the strobe
  always @(posedge clk) rd_seen <= cpu_rd;
  always @(negedge clk)
    if (rd_seen)
      check_rd(cpu_rdata, exp_q.pop_front());

  initial
  begin
    #200000;
    n_mismatch++;
    tally_and_finish;
  end

  initial
  begin
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    for (int a = 8'h42; a <= 8'h50; a++)
      rd(8'(a), 8'h00);
    wr(8'h43, 8'h80);
    rd(8'h43, 8'h00);
    wr(8'h47, 8'hFF);
    rd(8'h47, 8'h7F);
    wr(8'h44, 8'h54);
    check_flag(chip_reset, 1'b0);
    wr(8'h44, 8'h55);
    check_flag(chip_reset, 1'b1);
    wr(8'h45, 8'hFF);
    rd(8'h45, 8'h01);
    repeat (70) @(negedge clk);
    rd(8'h45, 8'h00);
    unlock(8'h01);
    rd(8'h43, 8'h60);
    wr(8'h43, 8'h68);
    for (int e = 1; e <= 9; e++)
    begin
      repeat (4) @(negedge clk);
      sub_clock = 1'b1;
      repeat (4) @(negedge clk);
      sub_clock = 1'b0;
      if (e >= 8)
        rd(8'h43, (e == 8) ? 8'h68 : 8'h60);
    end
    unlock(8'h00);
    rd(8'h43, 8'hE0);
    base = 15'($random(seed));
    wr(8'h46, base[7:0]);
    wr(8'h47, {1'b0, base[14:8]});
    wr(8'h43, 8'h94);
    check_flag(cpu_halt, 1'b1);
    wait_idle;
    rd(8'h43, 8'h90);
    fetch({base[14:6], 6'h00}, 16'hFFFF);
    fetch({base[14:6], 6'h3F}, 16'hFFFF);
    nxt = {base[14:6], 6'h00};
    wr(8'h46, nxt[7:0]);
    wr(8'h48, 8'h5A);
    rd(8'h46, nxt[7:0]);
    for (int i = 0; i < 64; i++)
    begin
      page_buf[i] = 16'($random(seed));
      wr(8'h48, page_buf[i][7:0]);
      wr(8'h49, page_buf[i][15:8]);
    end
    nxt = nxt + 15'd64;
    rd(8'h46, nxt[7:0]);
    rd(8'h47, {1'b0, nxt[14:8]});
    wr(8'h46, {base[7:6], 6'h00});
    wr(8'h47, {1'b0, base[14:8]});
    wr(8'h43, 8'h84);
    wait_idle;
    rd(8'h43, 8'h80);
    for (int i = 0; i < 3; i++)
    begin
      idx = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : 6'($random(seed));
      fetch({base[14:6], idx}, page_buf[idx]);
    end
    wr(8'h43, 8'h31);
    rd(8'h43, 8'h30);
    wr(8'h43, 8'h00);
    n0 = n_req;
    for (int m = 0; m < 8; m++)
      if (m != 3 && m != 6)
      begin
        wr(8'h43, {1'b0, 3'(m), 4'h4});
        rd(8'h43, {1'b0, 3'(m), 4'h0});
      end
    check_flag(n_req == n0, 1'b1);
    repeat (2) @(negedge clk);
    tally_and_finish;
  end
endmodule

// [verif/iap_flash_model.sv]
// Behavioural program flash array answering the controller's requests
`timescale 1ns/100ps
module iap_flash_model (
  input wire logic clk,
  input wire logic nrst,
  input wire iap_pkg::iap_flash_cmd_t flash_cmd,
  output logic flash_done,
  output logic [15:0] flash_rdata,
  output int n_req
);
  logic [15:0] mem [int];

  initial
  begin
    flash_done = 1'b0;
    flash_rdata = 16'hA5A5;
    n_req = 0;
    forever
    begin
      @(negedge clk);
      if (nrst === 1'b1 && flash_cmd.req === 1'b1)
      begin
        n_req++;
        // Latency of one to four cycles covers prompt and slow answers
        repeat (1 + n_req % 4) @(posedge clk);
        case (flash_cmd.op)
          iap_pkg::IAP_OP_WRITE: mem[flash_cmd.addr] = flash_cmd.wdata;
          iap_pkg::IAP_OP_ERASE:
            for (int i = 0; i < 64; i++)
              mem[flash_cmd.addr + i] = 16'hFFFF;
          default: flash_rdata <= mem.exists(flash_cmd.addr) ? mem[flash_cmd.addr] : 16'h0000;
        endcase
        flash_done <= 1'b1;
        @(posedge clk);
        flash_done <= 1'b0;
        // Word is gone once done falls
        flash_rdata <= ~flash_rdata;
      end
    end
  end
endmodule
